// ===== src/dcsio_pkg.sv
// Constants shared by the command slice of the drive interpreter.
// Assumes one 25 MHz clock and a command parser that hands over decoded fields.
package dcsio_pkg;

   // ======================================================================
   // Clock and timing
   // ======================================================================
   localparam int CLK_PERIOD_NS    = 40;          // 25 MHz
   localparam int NV_WRITE_TIME_NS = 10000000;    // Non-volatile write time, 10 ms
   localparam int NV_WRITE_CYCLES  = (NV_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ======================================================================
   // Command opcodes on the decoded command port
   // ======================================================================
   localparam logic [1:0] OP_REG_OR   = 2'h0;     // Register OR
   localparam logic [1:0] OP_SAVE     = 2'h1;     // save_params_cmd
   localparam logic [1:0] OP_DIR      = 2'h2;     // io_direction_cmd, set form
   localparam logic [1:0] OP_DIR_QRY  = 2'h3;     // io_direction_cmd, query form

   // ======================================================================
   // Queue entry layout
   // ======================================================================
   localparam int ENT_OP_LSB  = 0;
   localparam int ENT_RA_LSB  = 2;
   localparam int ENT_RB_LSB  = 6;
   localparam int ENT_PT_LSB  = 10;
   localparam int ENT_LT_LSB  = 13;
   localparam int ENT_W       = 21;

   // ======================================================================
   // Register file
   // ======================================================================
   localparam int         REG_AW    = 4;
   localparam int         REG_DW    = 32;
   localparam logic [3:0] ACC_INDEX = 4'h0;      // User register zero

   // ======================================================================
   // Status word bit positions
   // ======================================================================
   localparam int ST_ENABLED  = 0;    // 0001
   localparam int ST_SAMPLING = 1;    // 0002
   localparam int ST_FAULT    = 2;    // 0004
   localparam int ST_IN_POS   = 3;    // 0008
   localparam int ST_MOVING   = 4;    // 0010
   localparam int ST_JOGGING  = 5;    // 0020
   localparam int ST_STOPPING = 6;    // 0040
   localparam int ST_SAVING   = 8;    // 0100
   localparam int ST_ALARM    = 9;    // 0200
   localparam int ST_HOMING   = 10;   // 0400
   localparam int ST_WAITING  = 11;   // 0800
   localparam int ST_TIMING   = 12;   // 1000
   localparam int ST_ENC_CHK  = 13;   // 2000
   localparam int ST_PROGRAM  = 14;   // 4000
   localparam int ST_INIT     = 15;   // 8000

   // ======================================================================
   // ASCII characters
   // ======================================================================
   localparam logic [7:0] CH_I    = 8'h49;
   localparam logic [7:0] CH_O    = 8'h4F;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] CH_ONE  = 8'h31;
   localparam logic [7:0] CH_A_10 = 8'h37;        // 'A' minus ten

   // ======================================================================
   // Direction configuration
   // ======================================================================
   localparam int         IO_POINTS   = 4;
   localparam logic [3:0] DIR_RST_VAL = 4'hF;     // All points inputs

endpackage

// ===== src/dcsio_regfile.sv
// Data register memory: one write port, one read port with registered data.
// Assumes the caller settles write collisions before the write port.
`timescale 1ns/1ns
module dcsio_regfile
   import dcsio_pkg::*;
#(
   parameter int AW = REG_AW,
   parameter int DW = REG_DW
) (
   // Clock
   input  wire logic          i_clk,
   // Write port
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [DW-1:0] i_wdata,
   // Read port
   input  wire logic [AW-1:0] i_raddr,
   output logic      [DW-1:0] o_rdata
);

   // ======================================================================
   // Storage
   // ======================================================================
   logic [DW-1:0] mem_r [0:(1<<AW)-1];    // No reset: contents come from writes

   // Write, then registered read (old data on same-address collision)
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem_r[i_waddr] <= i_wdata;
      end
      o_rdata <= mem_r[i_raddr];
   end

endmodule

// ===== src/dcsio_cmd_fifo.sv
// Buffered-command queue, first in first out.
// Assumes the writer honours o_ready; writes while full are dropped.
`timescale 1ns/1ns
module dcsio_cmd_fifo
   import dcsio_pkg::*;
#(
   parameter int W     = ENT_W,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   // Fill side
   input  wire logic         i_valid,
   output logic              o_ready,
   input  wire logic [W-1:0] i_data,
   // Drain side
   output logic              o_valid,
   input  wire logic         i_pop,
   output logic      [W-1:0] o_data
);

   // ======================================================================
   // Pointers and occupancy
   // ======================================================================
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0]  buf_r [0:DEPTH-1];       // Entries
   logic [PW-1:0] wp_r;                     // Write pointer
   logic [PW-1:0] rp_r;                     // Read pointer
   logic [PW:0]   cnt_r;                    // Occupancy
   wire           push = i_valid && o_ready;
   wire           pop  = i_pop && o_valid;
   wire  [PW:0]   cnt_nxt = cnt_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};

   assign o_valid = (cnt_r != '0);
   assign o_data  = buf_r[rp_r];

   // Entry store
   always_ff @(posedge i_clk) begin
      if (push) begin
         buf_r[wp_r] <= i_data;
      end
   end

   // Pointers; ready is registered so the source sees a clean level
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wp_r    <= '0;
         rp_r    <= '0;
         cnt_r   <= '0;
         o_ready <= 1'b1;
      end else begin
         wp_r    <= push ? PW'(wp_r + 1'b1) : wp_r;
         rp_r    <= pop  ? PW'(rp_r + 1'b1) : rp_r;
         cnt_r   <= cnt_nxt;
         o_ready <= (cnt_nxt != (PW+1)'(DEPTH));
      end
   end

endmodule

// ===== src/dcsio_top.sv
// Command slice of a drive text interpreter: register OR, parameter save,
// status query and I/O direction set/query.
// Assumes a parser upstream decodes ASCII into fields; status inputs come
// from drive logic on the same clock.
//
// Operation
// - OR two registers into register zero
// - Math result updates five condition flags
// - Save copies non-volatile parameters to storage
// - Status query answered at once, hex digits
// - Status word is OR of active bits
// - Bits enabled, fault and alarm reported
// - In-position bit valid on servo only
// - Bits moving, jogging and stopping reported
// - Bits saving, homing and program reported
// - One waiting bit for input or delay
// - Bits timing, encoder check, init reported
// - Direction command sets point 1-4 I/O
// - Direction command without parameters reports all
// - Query answers digit 1 input, 0 output
`timescale 1ns/1ns
module dcsio_top
   import dcsio_pkg::*;
#(
   parameter int          QDEPTH     = 8,
   parameter int          SAVE_TICKS = NV_WRITE_CYCLES,
   parameter bit          SERVO_TYPE = 1'b1,
   parameter logic [3:0]  DIR_RESET  = DIR_RST_VAL
) (
   // Clock and reset
   input  wire logic                 I_CLK,
   input  wire logic                 I_RST,
   // Decoded buffered command
   input  wire logic                 I_CMD_VALID,
   output logic                      O_CMD_READY,
   input  wire logic [1:0]           I_CMD_OP,
   input  wire logic [REG_AW-1:0]    I_CMD_REG_A,
   input  wire logic [REG_AW-1:0]    I_CMD_REG_B,
   input  wire logic [2:0]           I_CMD_POINT,
   input  wire logic [7:0]           I_CMD_LETTER,
   // Outside write into the data registers
   input  wire logic                 I_REG_WR,
   input  wire logic [REG_AW-1:0]    I_REG_ADDR,
   input  wire logic [REG_DW-1:0]    I_REG_DATA,
   // Immediate status query
   input  wire logic                 I_STATUS_REQ,
   output logic                      O_STATUS_VALID,
   output logic [31:0]               O_STATUS_HEX,
   output logic [15:0]               O_STATUS_WORD,
   // Drive conditions
   input  wire logic                 I_ENABLED,
   input  wire logic                 I_SAMPLING,
   input  wire logic                 I_FAULT,
   input  wire logic                 I_IN_POS,
   input  wire logic                 I_MOVING,
   input  wire logic                 I_JOGGING,
   input  wire logic                 I_STOPPING,
   input  wire logic                 I_ALARM,
   input  wire logic                 I_HOMING,
   input  wire logic                 I_WAIT_INPUT,
   input  wire logic                 I_WAIT_TIME,
   input  wire logic                 I_TIMING,
   input  wire logic                 I_ENC_CHECK,
   input  wire logic                 I_PROGRAM,
   input  wire logic                 I_INIT,
   // Math results
   output logic [REG_DW-1:0]         O_ACC,
   output logic [4:0]                O_CC_FLAGS,
   // Direction configuration and query answer
   output logic [IO_POINTS-1:0]      O_DIR_CFG,
   output logic                      O_DIR_VALID,
   output logic [8*IO_POINTS-1:0]    O_DIR_ASCII,
   // Non-volatile store
   input  wire logic [IO_POINTS-1:0] I_NV_DIR,
   output logic [IO_POINTS-1:0]      O_NV_DIR,
   output logic                      O_NV_BUSY
);

   // ======================================================================
   // Helpers
   // ======================================================================
   // Nibble to upper-case ASCII hex digit
   function automatic logic [7:0] hex_char(input logic [3:0] n);
      hex_char = (n < 4'hA) ? (CH_ZERO + {4'h0, n}) : (CH_A_10 + {4'h0, n});
   endfunction

   // Command execution states
   typedef enum logic [2:0] {S_IDLE, S_RDA, S_RDB, S_EXEC, S_SAVE} dcsio_state_e;
   localparam int SCW = $clog2(SAVE_TICKS + 1);

   dcsio_state_e          state_r;          // Executor state
   logic [ENT_W-1:0]      ent_r;            // Command being executed
   logic [REG_DW-1:0]     opa_r;            // First operand
   logic [SCW-1:0]        save_cnt_r;       // Write time remaining
   logic                  boot_r;           // Restore pending after reset
   logic [REG_DW-1:0]     rdata;
   logic [ENT_W-1:0]      q_data;
   logic                  q_valid;

   // ======================================================================
   // Command queue
   // ======================================================================
   wire [ENT_W-1:0] q_in = {I_CMD_LETTER, I_CMD_POINT, I_CMD_REG_B, I_CMD_REG_A, I_CMD_OP};
   wire             q_pop = (state_r == S_IDLE) && !boot_r;

   // Buffered commands run in arrival order
   dcsio_cmd_fifo #(.W(ENT_W), .DEPTH(QDEPTH)) u_fifo (
      .i_clk   (I_CLK),
      .i_rst   (I_RST),
      .i_valid (I_CMD_VALID),
      .o_ready (O_CMD_READY),
      .i_data  (q_in),
      .o_valid (q_valid),
      .i_pop   (q_pop),
      .o_data  (q_data)
   );

   // ======================================================================
   // Decode of the entry under execution, and of the opcode at the queue head
   // ======================================================================
   wire [REG_AW-1:0] e_ra  = ent_r[ENT_RB_LSB-1:ENT_RA_LSB];
   wire [REG_AW-1:0] e_rb  = ent_r[ENT_PT_LSB-1:ENT_RB_LSB];
   wire [1:0]        h_op  = q_data[ENT_RA_LSB-1:ENT_OP_LSB];

   // ======================================================================
   // Data registers and OR arithmetic
   // ======================================================================
   wire [REG_AW-1:0] raddr   = (state_r == S_RDA) ? e_ra : e_rb;
   wire [REG_DW-1:0] or_res  = opa_r | rdata;
   wire              acc_we  = (state_r == S_EXEC);
   wire              rf_we   = acc_we || I_REG_WR;
   wire [REG_AW-1:0] rf_wa   = acc_we ? ACC_INDEX : I_REG_ADDR;
   wire [REG_DW-1:0] rf_wd   = acc_we ? or_res : I_REG_DATA;
   // Flags T, F, N, P, Z from the result
   wire              f_z     = (or_res == '0);
   wire              f_n     = or_res[REG_DW-1];
   wire [4:0]        cc_nxt  = {!f_z, f_z, f_n, !f_n && !f_z, f_z};

   dcsio_regfile #(.AW(REG_AW), .DW(REG_DW)) u_regs (
      .i_clk   (I_CLK),
      .i_we    (rf_we),
      .i_waddr (rf_wa),
      .i_wdata (rf_wd),
      .i_raddr (raddr),
      .o_rdata (rdata)
   );

   // ======================================================================
   // Executor state machine
   // ======================================================================
   // One command at a time; a save holds the queue until storage is done
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         state_r    <= S_IDLE;
         ent_r      <= '0;
         opa_r      <= '0;
         save_cnt_r <= '0;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (q_valid && !boot_r) begin
                  ent_r <= q_data;
                  if (h_op == OP_REG_OR) begin
                     state_r <= S_RDA;
                  end else if (h_op == OP_SAVE) begin
                     state_r    <= S_SAVE;
                     save_cnt_r <= SCW'(SAVE_TICKS);
                  end else begin
                     state_r <= S_IDLE;                              // Direction ops
                  end
               end
            end
            S_RDA:   state_r <= S_RDB;
            S_RDB: begin
               opa_r   <= rdata;                                     // First operand
               state_r <= S_EXEC;
            end
            S_EXEC:  state_r <= S_IDLE;
            S_SAVE: begin
               save_cnt_r <= SCW'(save_cnt_r - 1'b1);
               if (save_cnt_r == SCW'(1)) begin
                  state_r <= S_IDLE;
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // Accumulator mirror and condition flags
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_ACC      <= '0;
         O_CC_FLAGS <= '0;
      end else if (acc_we) begin
         O_ACC      <= or_res;
         O_CC_FLAGS <= cc_nxt;
      end
   end

   // ======================================================================
   // Direction configuration and non-volatile copy
   // ======================================================================
   wire dir_set = (state_r == S_IDLE) && q_valid && !boot_r && (h_op == OP_DIR);
   wire dir_qry = (state_r == S_IDLE) && q_valid && !boot_r && (h_op == OP_DIR_QRY);
   wire save_go = (state_r == S_IDLE) && q_valid && !boot_r && (h_op == OP_SAVE);
   // Fields of the entry at the queue head, used for one-cycle direction ops
   wire [2:0] h_pt  = q_data[ENT_LT_LSB-1:ENT_PT_LSB];
   wire [7:0] h_lt  = q_data[ENT_W-1:ENT_LT_LSB];
   wire       h_ok  = (h_pt >= 3'h1) && (h_pt <= 3'(IO_POINTS)) && ((h_lt == CH_I) || (h_lt == CH_O));
   wire [1:0] h_ix  = 2'(h_pt - 3'h1);

   // Query answer: one digit per point, highest point first
   logic [8*IO_POINTS-1:0] dir_digits;
   genvar gi;
   generate
      for (gi = 0; gi < IO_POINTS; gi++) begin : g_dig
         assign dir_digits[8*gi +: 8] = O_DIR_CFG[gi] ? CH_ONE : CH_ZERO;
      end
   endgenerate

   // Boot restore, then set commands; bad point or letter is ignored
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         boot_r    <= 1'b1;
         O_DIR_CFG <= DIR_RESET;
      end else if (boot_r) begin
         boot_r    <= 1'b0;
         O_DIR_CFG <= I_NV_DIR;
      end else if (dir_set && h_ok) begin
         O_DIR_CFG[h_ix] <= (h_lt == CH_I);
      end
   end

   // Query answer pulse; settings unchanged
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_DIR_VALID <= 1'b0;
         O_DIR_ASCII <= '0;
      end else begin
         O_DIR_VALID <= dir_qry;
         O_DIR_ASCII <= dir_qry ? dir_digits : O_DIR_ASCII;
      end
   end

   // Snapshot of non-volatile parameters at the start of a save
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_NV_DIR  <= DIR_RESET;
         O_NV_BUSY <= 1'b0;
      end else begin
         O_NV_DIR  <= save_go ? O_DIR_CFG : O_NV_DIR;
         O_NV_BUSY <= save_go || ((state_r == S_SAVE) && (save_cnt_r != SCW'(1)));
      end
   end

   // ======================================================================
   // Status word and immediate answer
   // ======================================================================
   logic [15:0] stat_w;
   always_comb begin
      stat_w              = 16'h0000;
      stat_w[ST_ENABLED]  = I_ENABLED;
      stat_w[ST_SAMPLING] = I_SAMPLING;
      stat_w[ST_FAULT]    = I_FAULT;
      stat_w[ST_IN_POS]   = I_IN_POS && SERVO_TYPE;
      stat_w[ST_MOVING]   = I_MOVING;
      stat_w[ST_JOGGING]  = I_JOGGING;
      stat_w[ST_STOPPING] = I_STOPPING;
      stat_w[ST_SAVING]   = O_NV_BUSY;
      stat_w[ST_ALARM]    = I_ALARM;
      stat_w[ST_HOMING]   = I_HOMING;
      stat_w[ST_WAITING]  = I_WAIT_INPUT || I_WAIT_TIME;
      stat_w[ST_TIMING]   = I_TIMING;
      stat_w[ST_ENC_CHK]  = I_ENC_CHECK;
      stat_w[ST_PROGRAM]  = I_PROGRAM;
      stat_w[ST_INIT]     = I_INIT;
   end

   // Four hex digits, most significant first in the top byte
   logic [31:0] stat_hex;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_hex
         assign stat_hex[8*gi +: 8] = hex_char(stat_w[4*gi +: 4]);
      end
   endgenerate

   // Query bypasses the queue and answers next edge
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         O_STATUS_VALID <= 1'b0;
         O_STATUS_HEX   <= '0;
         O_STATUS_WORD  <= '0;
      end else begin
         O_STATUS_VALID <= I_STATUS_REQ;
         O_STATUS_HEX   <= I_STATUS_REQ ? stat_hex : O_STATUS_HEX;
         O_STATUS_WORD  <= stat_w;
      end
   end

   // ======================================================================
   // Checks
   // ======================================================================
   sequence s_or_start;
      (state_r == S_RDB);
   endsequence

   a_or_result: assert property (@(posedge I_CLK) disable iff (I_RST)
      s_or_start ##1 1'b1 |=> O_ACC == ($past(rdata, 2) | $past(rdata)))
      else $error("accumulator not the OR of operands");
   a_cc_zero: assert property (@(posedge I_CLK) disable iff (I_RST)
      acc_we |=> (O_CC_FLAGS[0] == (O_ACC == '0)) && (O_CC_FLAGS[2] == O_ACC[REG_DW-1]))
      else $error("condition flags disagree with result");
   a_status_answer: assert property (@(posedge I_CLK) disable iff (I_RST)
      I_STATUS_REQ |=> O_STATUS_VALID && (O_STATUS_HEX == $past(stat_hex)))
      else $error("status answer late or wrong");
   a_status_or: assert property (@(posedge I_CLK) disable iff (I_RST)
      1'b1 |=> O_STATUS_WORD[ST_ENABLED] == $past(I_ENABLED)
               && O_STATUS_WORD[ST_ALARM] == $past(I_ALARM)
               && O_STATUS_WORD[ST_FAULT] == $past(I_FAULT))
      else $error("status bits not mapped");
   a_wait_merge: assert property (@(posedge I_CLK) disable iff (I_RST)
      (I_WAIT_INPUT || I_WAIT_TIME) |=> O_STATUS_WORD[ST_WAITING])
      else $error("waiting bit missing");
   a_inpos_gate: assert property (@(posedge I_CLK) disable iff (I_RST)
      1'b1 |=> O_STATUS_WORD[ST_IN_POS] == ($past(I_IN_POS) && SERVO_TYPE))
      else $error("in-position bit on non-servo");
   a_save_hold: assert property (@(posedge I_CLK) disable iff (I_RST)
      save_go |=> O_NV_BUSY && (state_r == S_SAVE))
      else $error("saving bit not raised on save");
   a_save_end: assert property (@(posedge I_CLK) disable iff (I_RST)
      (state_r == S_SAVE) && (save_cnt_r == SCW'(1)) |=> !O_NV_BUSY && (state_r == S_IDLE))
      else $error("saving bit not cleared at end");
   a_dir_query: assert property (@(posedge I_CLK) disable iff (I_RST)
      dir_qry |=> O_DIR_VALID && $stable(O_DIR_CFG) && (O_DIR_ASCII[7:0] == (O_DIR_CFG[0] ? CH_ONE : CH_ZERO)))
      else $error("direction query wrong");
   a_dir_set: assert property (@(posedge I_CLK) disable iff (I_RST)
      dir_set && h_ok |=> O_DIR_CFG[$past(h_ix)] == ($past(h_lt) == CH_I))
      else $error("direction not applied");

endmodule

// ===== verif/dcsio_host.sv
// Host model: offers decoded buffered commands to the slice.
// Assumes the slice samples on the rising edge of i_clk.
`timescale 1ns/1ns
module dcsio_host (
   // Clock and queue room
   input  wire logic i_clk,
   input  wire logic i_ready,
   // Decoded command
   output logic       o_valid,
   output logic [1:0] o_op,
   output logic [3:0] o_ra,
   output logic [3:0] o_rb,
   output logic [2:0] o_pt,
   output logic [7:0] o_lt
);
   // Saves are sent sparsely, never from a loop
   initial {o_valid, o_op, o_ra, o_rb, o_pt, o_lt} = '0;
   // Opcode, two designators, point and letter, held until taken or for at most 50 cycles
   task automatic send(input logic [1:0] op, input logic [3:0] a, b,
                       input logic [2:0] p, input logic [7:0] l, output bit ok);
      ok = 0;
      @(negedge i_clk);
      {o_valid, o_op, o_ra, o_rb, o_pt, o_lt} = {1'b1, op, a, b, p, l};
      for (int i = 0; i < 50 && !ok; i++) begin
         ok = i_ready;
         @(posedge i_clk);
         @(negedge i_clk);
      end
      o_valid = 1'b0;
      // Released register fields do not keep their old value
      {o_ra, o_rb} = ~{o_ra, o_rb};
   endtask
endmodule

// ===== verif/dcsio_top_tb.sv
// Bench for the command slice: status, OR, direction, save.
// Assumes a 25 MHz clock and a five-tick save.
`timescale 1ns/1ns
`define CK(a, x) begin tests_run++; if ((a) !== (x)) begin miscompares++; \
   $display("BAD %0t %h %h", $time, a, x); end end
module dcsio_top_tb;
   import dcsio_pkg::*;
   logic I_CLK = 0, I_RST = 1, rq = 0, wr = 0, rdy, sv, dv, bz, hv;
   logic [3:0] wa = 0, nv, d, cfg, nvd, ha, hb;
   logic [31:0] wd = 0, hx, da, acc, e, qe;
   logic [15:0] c = 0, sw, ew;
   logic [1:0] hop;
   logic [2:0] hp;
   logic [7:0] hl;
   logic [4:0] fl;
   logic [31:0] q[$];
   int tests_run = 0, miscompares = 0, n;
   bit ok;
   // ==================================================================
   // Clock, host model and slice
   always #20 I_CLK = ~I_CLK;
   dcsio_host h (.i_clk(I_CLK), .i_ready(rdy), .o_valid(hv), .o_op(hop), .o_ra(ha),
      .o_rb(hb), .o_pt(hp), .o_lt(hl));
   dcsio_top #(.SAVE_TICKS(5)) dut (.I_CLK, .I_RST, .I_CMD_VALID(hv), .O_CMD_READY(rdy),
      .I_CMD_OP(hop), .I_CMD_REG_A(ha), .I_CMD_REG_B(hb), .I_CMD_POINT(hp),
      .I_CMD_LETTER(hl), .I_REG_WR(wr), .I_REG_ADDR(wa), .I_REG_DATA(wd),
      .I_STATUS_REQ(rq), .O_STATUS_VALID(sv), .O_STATUS_HEX(hx), .O_STATUS_WORD(sw),
      .I_ENABLED(c[0]), .I_SAMPLING(c[1]), .I_FAULT(c[2]), .I_IN_POS(c[3]),
      .I_MOVING(c[4]), .I_JOGGING(c[5]), .I_STOPPING(c[6]), .I_ALARM(c[9]),
      .I_HOMING(c[10]), .I_WAIT_INPUT(c[11]), .I_WAIT_TIME(c[7]), .I_TIMING(c[12]),
      .I_ENC_CHECK(c[13]), .I_PROGRAM(c[14]), .I_INIT(c[15]), .O_ACC(acc),
      .O_CC_FLAGS(fl), .O_DIR_CFG(cfg), .O_DIR_VALID(dv), .O_DIR_ASCII(da),
      .I_NV_DIR(nv), .O_NV_DIR(nvd), .O_NV_BUSY(bz));
   // Word to four upper-case hex characters
   function automatic logic [31:0] hexw(logic [15:0] w);
      for (int i = 0; i < 4; i++)
         hexw[8*i+:8] = (w[4*i+:4] < 10) ? CH_ZERO + w[4*i+:4] : CH_A_10 + w[4*i+:4];
   endfunction
   task automatic end_of_test;
      $display("run %0d bad %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // A refused command counts as a hang
   task automatic snd(logic [1:0] o, logic [2:0] p, logic [7:0] l);
      h.send(o, 4'h1, 4'h2, p, l, ok);
      if (!ok) begin miscompares++; end_of_test; end
   endtask
   // A wait that uses up its bound counts as a hang
   task automatic tmo;
      if (n >= 20) begin
         miscompares++;
         end_of_test;
      end
   endtask
   // Answers are matched against the oldest note
   always @(negedge I_CLK) if (sv === 1'b1 || dv === 1'b1) begin
      qe = q.size() ? q.pop_front() : 'x;
      `CK(sv ? hx : da, qe)
   end
   initial begin
      void'($urandom(32'h8E41));
      nv = 4'($urandom);
      repeat (3) @(negedge I_CLK);
      I_RST = 1'b0;
      `CK(rdy, 1'b1)
      for (int k = 0; k < 3; k++) begin
         c = 16'($urandom);
         repeat (2) @(negedge I_CLK);
         ew = {c[15:12], c[11] | c[7], c[10:9], 2'h0, c[6:0]};
         `CK(sw, ew)
         e = hexw(ew);
         q.push_back(e);
         q.push_back(e);
         rq = 1'b1;
         repeat (2) @(negedge I_CLK);
         rq = 1'b0;
      end
      $display("status done");
      for (int k = 0; k < 2; k++) begin
         e = 0;
         wr = 1'b1;
         for (int r = 1; r < 3; r++) begin
            wa = 4'(r);
            wd = k ? 32'h0 : $urandom;
            e |= wd;
            @(negedge I_CLK);
         end
         wr = 1'b0;
         snd(OP_REG_OR, 3'h0, 8'h0);
         for (n = 0; n < 20 && acc !== e; n++) @(negedge I_CLK);
         tmo;
         `CK(acc, e)
         `CK(fl, {e != 0, e == 0, e[31], !e[31] && e != 0, e == 0})
      end
      $display("or done");
      d = nv;
      d[1] = 1'b0;
      d[3] = 1'b1;
      snd(OP_DIR, 3'h2, CH_O);
      snd(OP_DIR, 3'h4, CH_I);
      snd(OP_DIR, 3'h1, 8'h58);
      for (int k = 0; k < 4; k++) e[8*k+:8] = d[k] ? CH_ONE : CH_ZERO;
      q.push_back(e);
      snd(OP_DIR_QRY, 3'h0, 8'h0);
      for (n = 0; n < 20 && q.size() > 0; n++) @(negedge I_CLK);
      tmo;
      `CK(cfg, d)
      $display("dir done");
      snd(OP_SAVE, 3'h0, 8'h0);
      for (n = 0; n < 20 && bz !== 1'b1; n++) @(negedge I_CLK);
      tmo;
      for (n = 0; n < 20 && bz === 1'b1; n++) begin
         if (n > 0) `CK(sw[ST_SAVING], 1'b1)
         @(negedge I_CLK);
      end
      tmo;
      `CK(n, 5)
      `CK(nvd, d)
      `CK(q.size(), 0)
      $display("save done");
      end_of_test;
   end
endmodule
